// ### shared/acr_pkg.sv
// Package: register map, field positions and encodings of the ADC control register bank
package acr_pkg;

  localparam logic [15:0] ADDR_FILTER_CTRL = 16'h0001;
  localparam logic [15:0] ADDR_POWER_CTRL  = 16'h0002;
  localparam logic [15:0] ADDR_OFFSET      = 16'h0003;
  localparam logic [15:0] ADDR_GAIN        = 16'h0004;
  localparam logic [15:0] ADDR_THRESHOLD   = 16'h0005;

  localparam logic [15:0] FILTER_CTRL_RESET = 16'h001A;
  localparam logic [15:0] POWER_CTRL_RESET  = 16'h009B;
  localparam logic [15:0] OFFSET_RESET      = 16'h0000;
  localparam logic [15:0] GAIN_RESET        = 16'hA000;
  localparam logic [15:0] THRESHOLD_RESET   = 16'hCCCC;

  localparam int BIT_COEFF_LOAD  = 15;
  localparam int BIT_RD_THRESH   = 14;
  localparam int BIT_RD_GAIN     = 13;
  localparam int BIT_RD_OFFSET   = 12;
  localparam int BIT_RD_STATUS   = 11;
  localparam int BIT_SYNC        = 9;
  localparam int FLEN_HI         = 8;
  localparam int FLEN_LO         = 5;
  localparam int BIT_STAGE3_USE  = 4;
  localparam int DEC_HI          = 2;
  localparam int BIT_CHIP_SLEEP  = 3;
  localparam int BIT_ECONOMY     = 2;
  localparam int BIT_AMP_SLEEP   = 0;
  localparam int STAT_LOAD_OK    = 7;

  // Self-clearing bits 15..9 are never stored
  localparam logic [15:0] FILTER_CTRL_KEEP = 16'h01FF;

  // Coefficients per step n of the length field (field is 2n-1 -> 6n)
  localparam logic [5:0] COEFF_PER_STEP = 6'h06;
  localparam logic [5:0] STATUS_PART_ID = 6'h00;  // Arbitrary identity value

  typedef enum logic [2:0] {ACR_RD_CONV, ACR_RD_THRESH, ACR_RD_GAIN,
                            ACR_RD_OFFSET, ACR_RD_STATUS} acr_rd_sel_t;
  typedef enum {ACR_IDLE, ACR_COEFF, ACR_SUM} acr_load_t;

endpackage

// ### core/acr_bank.sv
// Control register bank of a sigma-delta ADC: 32-bit write words, read redirect, coefficient download
//
// Functional notes
// R1: Host sends address, then 16-bit data.
// R2: Write word: address high, data low.
// R3: Filter control at 0x001, resets 0x001A.
// R4: Coefficient load takes following coefficient writes.
// R5: Host sets length with load bit.
// R6: Bit 14 redirects next read: threshold.
// R7: Bit 13 redirects next read: gain.
// R8: Bit 12 redirects next read: offset.
// R9: Bit 11 redirects next read: status.
// R10: Host sets one redirect bit per write.
// R11: After redirected read, return conversion results.
// R12: Bits 15 to 9 self-clear.
// R13: Host writes 0 to bit 10.
// R14: Host writes ones to reserved one-bits.
// R15: Bit 9 starts filter synchronisation.
// R16: Bit 4 low bypasses third stage.
// R17: Decimation field sets second-stage ratio.
// R18: Power control at 0x002, resets 0x009B.
// R19: Power bit 3 sleeps whole chip.
// R20: Power bit 2 selects economy operation.
// R21: Power bit 0 sleeps input amplifier.
// R22: Checksum match sets status bit 7.
// R23: Offset, gain, threshold at 0x003..0x005.
`timescale 1ns/100ps
`default_nettype none

module acr_bank
  import acr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_valid,
  input  wire logic [31:0] wr_word,
  input  wire logic        rd_req,
  input  wire logic [23:0] conv_result,
  input  wire logic        overrange,
  output logic      [23:0] rd_data,
  output logic             rd_valid,
  output logic             sync_start,
  output logic             stage3_use,
  output logic      [5:0]  stage2_ratio,
  output logic      [3:0]  coeff_count_select,
  output logic             coeff_wr,
  output logic      [23:0] coeff_data,
  output logic             load_busy,
  output logic             load_sum_match,
  output logic             chip_sleep,
  output logic             economy_operation,
  output logic             input_amp_sleep
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [5:0] ratio_of(input logic [2:0] code);
    case (code)
      3'h3:    ratio_of = 6'h08;
      3'h4:    ratio_of = 6'h10;
      3'h5:    ratio_of = 6'h20;
      default: ratio_of = 6'h04;
    endcase
  endfunction

  function automatic logic [15:0] byte_sum(input logic [31:0] w);
    byte_sum = {8'h00, w[31:24]} + {8'h00, w[23:16]} + {8'h00, w[15:8]} + {8'h00, w[7:0]};
  endfunction

  // Even length codes round down; a 4-bit sum would wrap for the longest filter
  function automatic logic [5:0] coeff_total(input logic [3:0] flen);
    case (flen)
      4'h1, 4'h2: coeff_total = COEFF_PER_STEP * 6'h01;
      4'h3, 4'h4: coeff_total = COEFF_PER_STEP * 6'h02;
      4'h5, 4'h6: coeff_total = COEFF_PER_STEP * 6'h03;
      4'h7, 4'h8: coeff_total = COEFF_PER_STEP * 6'h04;
      4'h9, 4'hA: coeff_total = COEFF_PER_STEP * 6'h05;
      4'hB, 4'hC: coeff_total = COEFF_PER_STEP * 6'h06;
      4'hD, 4'hE: coeff_total = COEFF_PER_STEP * 6'h07;
      4'hF:       coeff_total = COEFF_PER_STEP * 6'h08;
      default:    coeff_total = 6'h00;
    endcase
  endfunction

  function automatic acr_rd_sel_t rd_target(input logic [15:0] dat);
    // Priority only matters if the host breaks the one-bit-per-write rule
    if (dat[BIT_RD_THRESH]) begin
      rd_target = ACR_RD_THRESH;                              // [R6]
    end else if (dat[BIT_RD_GAIN]) begin
      rd_target = ACR_RD_GAIN;                                // [R7]
    end else if (dat[BIT_RD_OFFSET]) begin
      rd_target = ACR_RD_OFFSET;                              // [R8]
    end else if (dat[BIT_RD_STATUS]) begin
      rd_target = ACR_RD_STATUS;                              // [R9]
    end else begin
      rd_target = ACR_RD_CONV;
    end
  endfunction

  logic [15:0] filter_ctrl;
  logic [15:0] power_ctrl;
  logic [15:0] offset_reg;
  logic [15:0] gain_reg;
  logic [15:0] thresh_reg;
  acr_rd_sel_t rd_sel;
  acr_load_t   load_state;
  logic [5:0]  coeff_left;
  logic [15:0] sum_acc;
  logic [15:0] status_word;
  logic [15:0] wr_addr;
  logic [15:0] wr_dat;
  logic        ctrl_wr;
  logic        reg_phase;

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  assign wr_addr   = wr_word[31:16];
  assign wr_dat    = wr_word[15:0];
  // Writes during a download belong to the coefficient stream, not the map
  assign reg_phase = wr_valid && (load_state == ACR_IDLE); // [R2] [R4]
  assign ctrl_wr   = reg_phase && (wr_addr == ADDR_FILTER_CTRL);

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  always_comb begin
    status_word                = 16'h0000;
    status_word[15:10]         = STATUS_PART_ID;
    status_word[9]             = power_ctrl[BIT_ECONOMY];
    status_word[8]             = overrange;
    status_word[STAT_LOAD_OK]  = load_sum_match;                // [R22]
    // Filter-pass check not modelled, reads 0
    status_word[6]             = 1'b0;
    status_word[5]             = (filter_ctrl[FLEN_HI:FLEN_LO] != 4'h0);
    status_word[4]             = ~filter_ctrl[BIT_STAGE3_USE];
    status_word[3]             = 1'b1;
    status_word[2:0]           = filter_ctrl[DEC_HI:0];
  end

  // ---------------------------------------------------------------
  // Stored registers
  // ---------------------------------------------------------------
  // Self-clearing bits never reach storage; sync gives a pulse, redirect and load bits set state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_ctrl <= FILTER_CTRL_RESET;                       // [R3]
    end else if (ctrl_wr) begin
      filter_ctrl <= wr_dat & FILTER_CTRL_KEEP;               // [R12]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_ctrl <= POWER_CTRL_RESET;                         // [R18]
    end else if (reg_phase && (wr_addr == ADDR_POWER_CTRL)) begin
      power_ctrl <= wr_dat;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      offset_reg <= OFFSET_RESET;
    end else if (reg_phase && (wr_addr == ADDR_OFFSET)) begin
      offset_reg <= wr_dat;                                   // [R23]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gain_reg <= GAIN_RESET;
    end else if (reg_phase && (wr_addr == ADDR_GAIN)) begin
      gain_reg <= wr_dat;                                     // [R23]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thresh_reg <= THRESHOLD_RESET;
    end else if (reg_phase && (wr_addr == ADDR_THRESHOLD)) begin
      thresh_reg <= wr_dat;                                   // [R23]
    end
  end

  // ---------------------------------------------------------------
  // Configuration outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage3_use         <= 1'b0;
      stage2_ratio       <= 6'h04;
      coeff_count_select <= 4'h0;
    end else begin
      stage3_use         <= filter_ctrl[BIT_STAGE3_USE];       // [R16]
      stage2_ratio       <= ratio_of(filter_ctrl[DEC_HI:0]);   // [R17]
      coeff_count_select <= filter_ctrl[FLEN_HI:FLEN_LO];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chip_sleep         <= 1'b0;
      economy_operation  <= 1'b0;
      input_amp_sleep    <= 1'b0;
    end else begin
      chip_sleep         <= power_ctrl[BIT_CHIP_SLEEP];        // [R19]
      economy_operation  <= power_ctrl[BIT_ECONOMY];           // [R20]
      input_amp_sleep    <= power_ctrl[BIT_AMP_SLEEP];         // [R21]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_start         <= 1'b0;
    end else begin
      // One-cycle pulse; several devices written together align their filters
      sync_start         <= ctrl_wr && wr_dat[BIT_SYNC];       // [R15] [R12]
    end
  end

  // ---------------------------------------------------------------
  // Read redirect
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_sel <= ACR_RD_CONV;
    end else if (ctrl_wr && (rd_target(wr_dat) != ACR_RD_CONV)) begin
      rd_sel <= rd_target(wr_dat);                            // [R6] [R7] [R8] [R9]
    end else if (rd_req) begin
      rd_sel <= ACR_RD_CONV;                                  // [R11]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data  <= 24'h00_0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_req;
      if (rd_req) begin
        case (rd_sel)
          ACR_RD_THRESH: rd_data <= {thresh_reg, 8'h00};      // [R6]
          ACR_RD_GAIN:   rd_data <= {gain_reg, 8'h00};        // [R7]
          ACR_RD_OFFSET: rd_data <= {offset_reg, 8'h00};      // [R8]
          ACR_RD_STATUS: rd_data <= {status_word, 8'h00};     // [R9]
          default:       rd_data <= conv_result;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Coefficient download
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_state     <= ACR_IDLE;
      coeff_left     <= 6'h00;
      sum_acc        <= 16'h0000;
      load_sum_match <= 1'b0;
      coeff_wr       <= 1'b0;
      coeff_data     <= 24'h00_0000;
      load_busy      <= 1'b0;
    end else begin
      coeff_wr <= 1'b0;
      case (load_state)
        ACR_IDLE: begin
          // A zero length field means default filter: nothing to take
          if (ctrl_wr && wr_dat[BIT_COEFF_LOAD] && (wr_dat[FLEN_HI:FLEN_LO] != 4'h0)) begin
            load_state     <= ACR_COEFF;                      // [R4]
            coeff_left     <= coeff_total(wr_dat[FLEN_HI:FLEN_LO]);
            sum_acc        <= 16'h0000;
            load_sum_match <= 1'b0;
            load_busy      <= 1'b1;
          end
        end
        ACR_COEFF: begin
          if (wr_valid) begin
            coeff_wr   <= 1'b1;                               // [R4]
            coeff_data <= wr_word[23:0];
            sum_acc    <= sum_acc + byte_sum(wr_word);        // [R22]
            coeff_left <= coeff_left - 6'h01;
            if (coeff_left == 6'h01) begin
              load_state <= ACR_SUM;
            end
          end
        end
        ACR_SUM: begin
          if (wr_valid) begin
            load_sum_match <= (wr_dat == sum_acc);            // [R22]
            load_state     <= ACR_IDLE;
            load_busy      <= 1'b0;
          end
        end
        default: load_state <= ACR_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ### tb/acr_host.sv
// Host model: drives write words and read pulses into the register bank
`timescale 1ns/100ps
`default_nettype none
module acr_host
  import acr_pkg::*;
(
  input  wire logic        clk,
  output logic             wr_valid,
  output logic      [31:0] wr_word,
  output logic             rd_req
);
  initial begin
    wr_valid = 1'b0;
    wr_word  = 32'h0000_0000;
    rd_req   = 1'b0;
  end
  // Address in the upper half, data in the lower half
  task automatic put(input logic [31:0] w);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_word  <= w;
  endtask
  // Reserved control bits forced to their required levels
  task automatic wr(input logic [31:0] w);
    if (w[31:16] == ADDR_FILTER_CTRL) w = (w & 32'hFFFF_FBFF) | 32'h0000_0008;
    if (w[31:16] == ADDR_POWER_CTRL) w = w | 32'h0000_0002;
    put(w);
  endtask
  // Released bus shows the inverse, so no stale word looks valid
  task automatic idle;
    @(posedge clk);
    wr_valid <= 1'b0;
    wr_word  <= ~wr_word;
  endtask
  task automatic rd;
    idle;
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// ### tb/acr_bank_chk.sv
// Checker: port-level assertions for the control register bank
`timescale 1ns/100ps
`default_nettype none
module acr_bank_chk
  import acr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wr_valid,
  input wire logic [31:0] wr_word,
  input wire logic        rd_req,
  input wire logic        rd_valid,
  input wire logic        sync_start,
  input wire logic        stage3_use,
  input wire logic [5:0]  stage2_ratio,
  input wire logic        coeff_wr,
  input wire logic [23:0] coeff_data,
  input wire logic        load_busy,
  input wire logic        chip_sleep,
  input wire logic        economy_operation,
  input wire logic        input_amp_sleep
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Words taken during a download are not register writes
  wire logic       ctl = wr_valid && !load_busy && wr_word[31:16] == ADDR_FILTER_CTRL;
  wire logic       pwr = wr_valid && !load_busy && wr_word[31:16] == ADDR_POWER_CTRL;
  wire logic [2:0] dec = wr_word[2:0];
  wire logic [5:0] rat = dec == 3'h3 ? 6'h08 : dec == 3'h4 ? 6'h10 : dec == 3'h5 ? 6'h20 : 6'h04;
  a_sync_start: assert property (ctl && wr_word[BIT_SYNC] |=> sync_start) else $error("sync pulse missing");
  a_sync_clears: assert property (!ctl |=> !sync_start) else $error("sync pulse stuck");
  a_read_answer: assert property (rd_req |=> rd_valid) else $error("read not answered");
  a_read_quiet: assert property (!rd_req |=> !rd_valid) else $error("read valid unasked");
  a_stage3_level: assert property (ctl ##1 !wr_valid |=> stage3_use == $past(wr_word[4], 2)) else $error("stage3");
  a_ratio_map: assert property (ctl ##1 !wr_valid |=> stage2_ratio == $past(rat, 2)) else $error("ratio wrong");
  a_power_bits: assert property (pwr ##1 !wr_valid |=> {chip_sleep, economy_operation, input_amp_sleep} ==
    {$past(wr_word[3], 2), $past(wr_word[2], 2), $past(wr_word[0], 2)}) else $error("power bits wrong");
  a_coeff_take: assert property (coeff_wr |-> $past(wr_valid) && coeff_data == $past(wr_word[23:0])) else $error("coeff");
endmodule
`default_nettype wire

// ### tb/acr_bank_tb.sv
// Testbench: random and corner-case traffic through the control register bank
`timescale 1ns/100ps
`default_nettype none
module acr_bank_tb
  import acr_pkg::*;
;
  logic             clk, rst, overrange;
  logic      [23:0] conv_result;
  wire logic        wr_valid, rd_req, rd_valid, sync_start, stage3_use, coeff_wr, load_busy, load_sum_match;
  wire logic        chip_sleep, economy_operation, input_amp_sleep;
  wire logic [31:0] wr_word;
  wire logic [23:0] rd_data, coeff_data;
  wire logic [5:0]  stage2_ratio;
  wire logic [3:0]  coeff_count_select;
  int               seed = 59898, bad_count, checked, cyc, ncoef;
  logic      [15:0] cw, pw, sum;
  logic      [31:0] cf [12] = '{32'h032B_9688, 32'h01BF_183C, 32'h0015_6626, 32'h04A8_1E6A, 32'h045F_2A96,
    32'h002C_49C2, 32'h0050_E9F6, 32'h0010_DBD8, 32'h042F_DE54, 32'h0437_445A, 32'h041B_7D6E, 32'h0404_3B5F};
  acr_host host (.clk(clk), .wr_valid(wr_valid), .wr_word(wr_word), .rd_req(rd_req));
  acr_bank dut (.clk(clk), .rst(rst), .wr_valid(wr_valid), .wr_word(wr_word), .rd_req(rd_req),
    .conv_result(conv_result), .overrange(overrange), .rd_data(rd_data), .rd_valid(rd_valid),
    .sync_start(sync_start), .stage3_use(stage3_use), .stage2_ratio(stage2_ratio),
    .coeff_count_select(coeff_count_select), .coeff_wr(coeff_wr), .coeff_data(coeff_data), .load_busy(load_busy),
    .load_sum_match(load_sum_match), .chip_sleep(chip_sleep), .economy_operation(economy_operation),
    .input_amp_sleep(input_amp_sleep));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (coeff_wr === 1'b1) ncoef++;
    if (cyc == 3000) begin
      bad_count++;
      close_out;
    end
  end
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic settle;
    @(posedge clk);
    #1;
  endtask
  function automatic logic [5:0] rat(input logic [2:0] d);
    return d == 3'h3 ? 6'h08 : d == 3'h4 ? 6'h10 : d == 3'h5 ? 6'h20 : 6'h04;
  endfunction
  function automatic logic [23:0] stat(input logic m);
    return {6'h00, pw[2], overrange, m, 1'b0, cw[8:5] != 4'h0, !cw[4], 1'b1, cw[2:0], 8'h00};
  endfunction
  initial begin
    rst = 1'b1;
    overrange = 1'b0;
    conv_result = 24'h00_0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle;
    chk("reset", {14'h0, stage2_ratio, chip_sleep, economy_operation, input_amp_sleep, stage3_use}, 24'h00_004B);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      cw = 16'($random(seed)) & 16'h03F8 | 16'(i);
      pw = 16'($random(seed));
      host.wr({ADDR_FILTER_CTRL, cw});
      host.wr({ADDR_POWER_CTRL, pw});
      host.idle;
      settle;
      chk("stage3", {23'h0, stage3_use}, {23'h0, cw[4]});
      chk("ratio", {18'h0, stage2_ratio}, {18'h0, rat(cw[2:0])});
      chk("length", {20'h0, coeff_count_select}, {20'h0, cw[8:5]});
      chk("power", {21'h0, chip_sleep, economy_operation, input_amp_sleep}, {21'h0, pw[3], pw[2], pw[0]});
    end
    $display("test config done");
    for (int i = 0; i < 4; i++) begin
      cw = 16'($random(seed)) & 16'h01FF | 16'h4000 >> i;
      host.wr({ADDR_FILTER_CTRL, cw});
      conv_result <= 24'($random(seed));
      overrange <= 1'($random(seed));
      host.rd;
      chk("redirect", rd_data, i == 0 ? {THRESHOLD_RESET, 8'h00} : i == 1 ? {GAIN_RESET, 8'h00} :
        i == 2 ? {OFFSET_RESET, 8'h00} : stat(1'b0));
      host.rd;
      chk("plain", rd_data, conv_result);
      chk("rd_valid", {23'h0, rd_valid}, 24'h00_0001);
    end
    $display("test redirect done");
    sum = 16'h0000;
    foreach (cf[k]) sum += cf[k][31:24] + cf[k][23:16] + cf[k][15:8] + cf[k][7:0];
    ncoef = 0;
    host.wr(32'h0001_807A);
    foreach (cf[k]) host.put(cf[k]);
    host.put({16'h0000, sum});
    host.idle;
    for (int k = 0; k < 50 && load_busy !== 1'b0; k++) settle;
    chk("coeffs", 24'(ncoef), 24'h00_000C);
    cw = 16'h087A;
    host.wr({ADDR_FILTER_CTRL, cw});
    host.rd;
    chk("load status", rd_data, stat(1'b1));
    chk("match", {23'h0, load_sum_match}, 24'h00_0001);
    $display("test download done");
    sum <<= 2;
    ncoef = 0;
    host.wr(32'h0001_81EA);
    for (int k = 0; k < 48; k++) host.put(cf[k % 12]);
    host.put({16'h0000, sum});
    host.idle;
    for (int k = 0; k < 50 && load_busy !== 1'b0; k++) settle;
    chk("long coeffs", 24'(ncoef), 24'h00_0030);
    chk("long match", {23'h0, load_sum_match}, 24'h00_0001);
    $display("test long download done");
    close_out;
  end
endmodule
bind acr_bank acr_bank_chk chk_i (.clk(clk), .rst(rst), .wr_valid(wr_valid), .wr_word(wr_word), .rd_req(rd_req),
  .rd_valid(rd_valid), .sync_start(sync_start), .stage3_use(stage3_use), .stage2_ratio(stage2_ratio),
  .coeff_wr(coeff_wr), .coeff_data(coeff_data), .load_busy(load_busy), .chip_sleep(chip_sleep),
  .economy_operation(economy_operation), .input_amp_sleep(input_amp_sleep));
`default_nettype wire
